// ### hw/nvsr_host.sv
// host controller driving a byte-wide nonvolatile static memory
// assumes the memory pins are synchronous to sys_clk; the busy pin is
// open-drain with an external pull-up, the testbench resolves the wires
`timescale 1ns/1ps
`include "nvsr_cfg.svh"

module nvsr_host
    import nvsr_pkg::*;
#(
    parameter int unsigned GRACE_CYC  = `NVSR_GRACE_US  * `NVSR_CLK_MHZ,
    parameter int unsigned STORE_CYC  = `NVSR_STORE_US  * `NVSR_CLK_MHZ,
    parameter int unsigned RECALL_CYC = `NVSR_RECALL_US * `NVSR_CLK_MHZ,
    parameter int unsigned PWRUP_CYC  = `NVSR_PWRUP_US  * `NVSR_CLK_MHZ
) (
    input  wire logic                sys_clk,      // system clock
    input  wire logic                nrst,         // sync reset, active low
    input  wire logic                req_valid,    // user request present
    output logic                     req_ready,    // request taken
    input  wire nvsr_req_t           req,          // command, addr, data
    output logic                     rsp_valid,    // one-cycle completion
    output logic [`NVSR_DW-1:0]      rsp_rdata,    // read data
    output logic                     dev_busy,     // device busy pin is low
    output nvsr_mem_ctl_t            mem_ctl,      // address and strobes
    output logic [`NVSR_DW-1:0]      mem_dq_o,     // data to memory
    output logic                     mem_dq_oe,    // data drive enable
    input  wire logic [`NVSR_DW-1:0] mem_dq_i,     // data from memory
    output logic                     hsb_n_o,      // store request level
    output logic                     hsb_n_oe,     // high while pulling low
    input  wire logic                hsb_n_i       // store_request_busy_n
);
    localparam logic [`NVSR_TW-1:0] GRACE_T  = GRACE_CYC[`NVSR_TW-1:0];
    localparam logic [`NVSR_TW-1:0] STORE_T  = STORE_CYC[`NVSR_TW-1:0];
    localparam logic [`NVSR_TW-1:0] RECALL_T = RECALL_CYC[`NVSR_TW-1:0];
    localparam logic [`NVSR_TW-1:0] PWRUP_T  = PWRUP_CYC[`NVSR_TW-1:0];

    // ------------------------------------------------------------
    // sequence address table
    // ------------------------------------------------------------
    function automatic logic [`NVSR_AW-1:0] seq_addr(
        input logic [2:0] idx,
        input nvsr_cmd_t  cmd
    );
        logic [15:0] a;
        a = `NVSR_FIN_STORE;
        case (idx)
            3'h0:    a = `NVSR_SEQ0;
            3'h1:    a = `NVSR_SEQ1;
            3'h2:    a = `NVSR_SEQ2;
            3'h3:    a = `NVSR_SEQ3;
            3'h4:    a = `NVSR_SEQ4;
            default:
            begin
                case (cmd)
                    CMD_RECALL:   a = `NVSR_FIN_RECALL;
                    CMD_AUTO_OFF: a = `NVSR_FIN_AUTO_OFF;
                    CMD_AUTO_ON:  a = `NVSR_FIN_AUTO_ON;
                    default:      a = `NVSR_FIN_STORE;
                endcase
            end
        endcase
        // top address bit plays no part in command detection
        return {1'b0, a};
    endfunction : seq_addr

    // ------------------------------------------------------------
    // control state
    // ------------------------------------------------------------
    nvsr_state_t            st_q, st_d;
    nvsr_cmd_t              cmd_q, cmd_d;
    logic [`NVSR_AW-1:0]    addr_q, addr_d;
    logic [`NVSR_DW-1:0]    wdata_q, wdata_d;
    logic [`NVSR_DW-1:0]    rdata_q, rdata_d;
    logic [2:0]             idx_q, idx_d;
    logic [`NVSR_TW-1:0]    tmr_q, tmr_d;
    logic                   rsp_q, rsp_d;
    logic                   is_seq;
    logic                   tmr_zero;

    assign is_seq   = (cmd_q != CMD_READ) && (cmd_q != CMD_WRITE)
                      && (cmd_q != CMD_HW_STORE);
    assign tmr_zero = (tmr_q == '0);
    // a low busy pin also covers low supply and device-started stores
    assign req_ready = (st_q == ST_IDLE) && hsb_n_i;

    always_comb
    begin
        st_d    = st_q;
        cmd_d   = cmd_q;
        addr_d  = addr_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        idx_d   = idx_q;
        tmr_d   = tmr_zero ? tmr_q : tmr_q - 1'b1;
        rsp_d   = 1'b0;
        case (st_q)
            ST_PWRUP:
            begin
                if (tmr_zero)
                    st_d = ST_IDLE;
            end
            ST_IDLE:
            begin
                if (req_valid && req_ready)
                begin
                    cmd_d   = req.cmd;
                    wdata_d = req.wdata;
                    idx_d   = 3'h0;
                    if (req.cmd == CMD_HW_STORE)
                    begin
                        st_d  = ST_HSB_DRV;
                        tmr_d = GRACE_T - 1'b1;
                    end
                    else
                    begin
                        st_d   = ST_ACC;
                        tmr_d  = `NVSR_ACC_CYC - 1'b1;
                        addr_d = (req.cmd == CMD_READ || req.cmd == CMD_WRITE)
                                 ? req.addr : seq_addr(3'h0, req.cmd);
                    end
                end
            end
            ST_ACC:
            begin
                if (tmr_zero)
                begin
                    rdata_d = mem_dq_i;
                    if (!is_seq)
                    begin
                        st_d  = ST_IDLE;
                        rsp_d = 1'b1;
                    end
                    else if (idx_q != `NVSR_SEQ_LAST)
                    begin
                        idx_d  = idx_q + 1'b1;
                        addr_d = seq_addr(idx_q + 1'b1, cmd_q);
                        st_d   = ST_GAP;
                    end
                    else if (cmd_q == CMD_AUTO_OFF || cmd_q == CMD_AUTO_ON)
                    begin
                        // setting only survives power-down once stored
                        // host never assumes the delivered setting
                        cmd_d  = CMD_STORE;
                        idx_d  = 3'h0;
                        addr_d = seq_addr(3'h0, CMD_STORE);
                        st_d   = ST_GAP;
                    end
                    else
                    begin
                        st_d  = ST_WAIT;
                        // recall never rewrites nonvolatile data: no store
                        tmr_d = (cmd_q == CMD_RECALL) ? RECALL_T : STORE_T;
                    end
                end
            end
            ST_GAP:
            begin
                st_d  = ST_ACC;
                tmr_d = `NVSR_ACC_CYC - 1'b1;
            end
            ST_WAIT:
            begin
                if (tmr_zero && hsb_n_i)
                begin
                    st_d  = ST_IDLE;
                    rsp_d = 1'b1;
                end
            end
            ST_HSB_DRV:
            begin
                if (tmr_zero)
                begin
                    st_d  = ST_HSB_WAIT;
                    tmr_d = `NVSR_SETTLE_CYC;
                end
            end
            ST_HSB_WAIT:
            begin
                // a skipped store lets the pin rise at once
                if (tmr_zero && hsb_n_i)
                begin
                    st_d  = ST_IDLE;
                    rsp_d = 1'b1;
                end
            end
            default:
            begin
                st_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            st_q    <= ST_PWRUP;
            cmd_q   <= CMD_READ;
            addr_q  <= '0;
            wdata_q <= '0;
            rdata_q <= '0;
            idx_q   <= 3'h0;
            tmr_q   <= PWRUP_T;
            rsp_q   <= 1'b0;
        end
        else
        begin
            st_q    <= st_d;
            cmd_q   <= cmd_d;
            addr_q  <= addr_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            idx_q   <= idx_d;
            tmr_q   <= tmr_d;
            rsp_q   <= rsp_d;
        end
    end

    // ------------------------------------------------------------
    // pin decode
    // ------------------------------------------------------------
    assign mem_ctl.addr = addr_q;
    assign mem_ctl.ce_n = (st_q != ST_ACC);
    assign mem_ctl.we_n = !((st_q == ST_ACC) && (cmd_q == CMD_WRITE));
    assign mem_ctl.oe_n = !((st_q == ST_ACC) && (cmd_q != CMD_WRITE));
    assign mem_dq_o     = wdata_q;
    assign mem_dq_oe    = (st_q == ST_ACC) && (cmd_q == CMD_WRITE);
    assign hsb_n_o      = 1'b0;
    assign hsb_n_oe     = (st_q == ST_HSB_DRV);
    assign rsp_valid    = rsp_q;
    assign rsp_rdata    = rdata_q;
    assign dev_busy     = !hsb_n_i;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    sequence s_auto_last;
        st_q == ST_ACC && tmr_zero && idx_q == `NVSR_SEQ_LAST
            && (cmd_q == CMD_AUTO_OFF || cmd_q == CMD_AUTO_ON);
    endsequence
    sequence s_store_follows;
        cmd_q == CMD_STORE && st_q == ST_GAP ##1 st_q == ST_ACC
            && mem_ctl.addr[15:0] == `NVSR_SEQ0;
    endsequence

    a_seq_read_only: assert property (is_seq && st_q == ST_ACC
        |-> mem_ctl.we_n && !mem_ctl.oe_n && !mem_dq_oe)
        else $error("sequence access is not a read");
    a_seq_first_addr: assert property (is_seq && st_q == ST_ACC
        && idx_q == 3'h0 |-> mem_ctl.addr == {1'b0, `NVSR_SEQ0})
        else $error("sequence does not start at first address");
    a_seq_store_fin: assert property (cmd_q == CMD_STORE && st_q == ST_ACC
        && idx_q == `NVSR_SEQ_LAST
        |-> mem_ctl.addr[15:0] == `NVSR_FIN_STORE)
        else $error("store sequence ends on wrong address");
    a_seq_ce_gap: assert property (is_seq && st_q == ST_ACC && tmr_zero
        && idx_q != `NVSR_SEQ_LAST |=> mem_ctl.ce_n ##1 !mem_ctl.ce_n)
        else $error("no chip enable gap between sequence reads");
    a_auto_then_store: assert property (s_auto_last |=> s_store_follows)
        else $error("setting change not followed by store");
    a_write_inhibit: assert property (!mem_ctl.we_n |-> hsb_n_i
        && !hsb_n_oe)
        else $error("write issued while busy pin low");
    a_busy_refuse: assert property (!hsb_n_i |-> !req_ready)
        else $error("request accepted while device busy");
    a_hsb_hold: assert property ($rose(hsb_n_oe) |-> hsb_n_oe [*8]
        ##0 mem_ctl.ce_n)
        else $error("store request released too early");
    a_wait_quiet: assert property (st_q == ST_WAIT
        |-> mem_ctl.ce_n && mem_ctl.we_n && !req_ready)
        else $error("memory touched during store or recall");
    a_pwrup_quiet: assert property (st_q == ST_PWRUP
        |-> mem_ctl.ce_n && !req_ready && !hsb_n_oe)
        else $error("access during power-up recall");
endmodule : nvsr_host

// ### common/nvsr_cfg.svh
// constants for the nonvolatile static memory store/recall host controller
// assumes a 25 MHz system clock and a 17-bit address, 8-bit data memory
`ifndef NVSR_CFG_SVH
`define NVSR_CFG_SVH
`define NVSR_CLK_MHZ       25
`define NVSR_AW            17
`define NVSR_DW            8
`define NVSR_TW            20
// times in microseconds, access and settle in cycles; other cycle counts are derived in the host module
`define NVSR_GRACE_US      25
`define NVSR_STORE_US      15
`define NVSR_RECALL_US     200
`define NVSR_PWRUP_US      20000
`define NVSR_ACC_CYC       20'h2
`define NVSR_SETTLE_CYC    20'h2
// command sequence addresses, lower 16 bits only
`define NVSR_SEQ0          16'h4e38
`define NVSR_SEQ1          16'hb1c7
`define NVSR_SEQ2          16'h83e0
`define NVSR_SEQ3          16'h7c1f
`define NVSR_SEQ4          16'h703f
`define NVSR_FIN_STORE     16'h8fc0
`define NVSR_FIN_RECALL    16'h4c63
`define NVSR_FIN_AUTO_OFF  16'h8b45
`define NVSR_FIN_AUTO_ON   16'h4b46
`define NVSR_SEQ_LAST      3'h5
`endif

// ### common/nvsr_pkg.sv
// types for the nonvolatile static memory store/recall host controller
// assumes nvsr_cfg.svh is on the include path
`include "nvsr_cfg.svh"
package nvsr_pkg;
    typedef enum logic [2:0] {
        CMD_READ, CMD_WRITE, CMD_STORE, CMD_RECALL,
        CMD_AUTO_OFF, CMD_AUTO_ON, CMD_HW_STORE
    } nvsr_cmd_t;

    typedef enum logic [2:0] {
        ST_PWRUP, ST_IDLE, ST_ACC, ST_GAP, ST_WAIT, ST_HSB_DRV, ST_HSB_WAIT
    } nvsr_state_t;

    typedef struct packed {
        nvsr_cmd_t              cmd;
        logic [`NVSR_AW-1:0]    addr;
        logic [`NVSR_DW-1:0]    wdata;
    } nvsr_req_t;

    typedef struct packed {
        logic [`NVSR_AW-1:0]    addr;
        logic                   ce_n;
        logic                   we_n;
        logic                   oe_n;
    } nvsr_mem_ctl_t;
endpackage : nvsr_pkg

// ### bench/nvsr_dev_model.sv
// behavioural model of the nonvolatile static memory seen by the host
// assumes host strobes change only on sys_clk edges; nrst acts as power
`timescale 1ns/1ps
`include "nvsr_cfg.svh"
module nvsr_dev_model
    import nvsr_pkg::*;
#(
    parameter int GRACE = 12,
    parameter int BUSY  = 10
) (
    input  wire logic                sys_clk,  // system clock
    input  wire logic                nrst,     // low while supply is down
    input  wire nvsr_mem_ctl_t       mem_ctl,  // host address and strobes
    input  wire logic [`NVSR_DW-1:0] dq_w,     // host write data
    input  wire logic                host_low, // host pulls busy pin low
    output logic [`NVSR_DW-1:0]      dq_r,     // read data
    output logic                     pull_low, // device busy pull
    output logic [7:0]               n_store,  // stores done
    output logic [7:0]               n_recall, // software recalls done
    output logic                     auto_en   // power-loss store enable
);
    // ----------------------------------------
    // state and decoder
    // ----------------------------------------
    logic [7:0]  sram [256];
    logic [7:0]  nv [256];
    logic [7:0]  last_q;
    logic [7:0]  st_q = 8'h00;
    logic [7:0]  rc_q = 8'h00;
    logic        auto_q = 1'b1;
    logic [15:0] seq [5] = '{`NVSR_SEQ0, `NVSR_SEQ1, `NVSR_SEQ2,
                             `NVSR_SEQ3, `NVSR_SEQ4};
    logic [2:0]  idx;
    logic        prev_ce, written, recall_req, armed;
    int          busy_t, grace_t;
    wire         start = prev_ce && !mem_ctl.ce_n;
    wire [15:0]  a = mem_ctl.addr[15:0];
    assign pull_low = busy_t > 0;
    assign n_store = st_q;
    assign n_recall = rc_q;
    assign auto_en = auto_q;
    // released bus toggles so a stale byte is never mistaken for data
    assign dq_r = (!mem_ctl.ce_n && !mem_ctl.oe_n && !pull_low)
                  ? sram[mem_ctl.addr[7:0]] : ~last_q;
    initial foreach (nv[i]) nv[i] = 8'(i);
    task automatic do_store();
        nv <= sram;
        st_q <= st_q + 8'h01;
        written <= 1'b0;
        armed <= 1'b0;
        busy_t <= BUSY;
    endtask : do_store
    always @(posedge sys_clk) begin
        last_q <= dq_r;
        prev_ce <= mem_ctl.ce_n;
        if (!nrst) begin
            recall_req <= 1'b1;
            busy_t <= 0;
            idx <= 3'h0;
            written <= 1'b0;
            grace_t <= 0;
            armed <= 1'b0;
        end else if (recall_req) begin
            sram <= nv;
            recall_req <= 1'b0;
        end else if (busy_t > 0) begin
            busy_t <= busy_t - 1;
        end else begin
            grace_t <= host_low ? grace_t + 1 : 0;
            if (start)
                armed <= 1'b1;
            if (!host_low && grace_t >= GRACE && written)
                do_store();
            else if (!mem_ctl.ce_n && !mem_ctl.we_n) begin
                idx <= 3'h0;
                if (!host_low && (armed || start)) begin
                    sram[mem_ctl.addr[7:0]] <= dq_w;
                    written <= 1'b1;
                end
            end else if (start && idx == `NVSR_SEQ_LAST) begin
                idx <= 3'h0;
                case (a)
                    `NVSR_FIN_STORE:    do_store();
                    `NVSR_FIN_RECALL:
                    begin
                        sram <= nv;
                        rc_q <= rc_q + 8'h01;
                        written <= 1'b0;
                        armed <= 1'b0;
                    end
                    `NVSR_FIN_AUTO_OFF: auto_q <= 1'b0;
                    `NVSR_FIN_AUTO_ON:  auto_q <= 1'b1;
                    default:            idx <= 3'h0;
                endcase
            end else if (start)
                idx <= (a == seq[idx]) ? idx + 3'h1
                       : {2'h0, a == seq[0]};
        end
    end
endmodule : nvsr_dev_model

// ### bench/nvsr_store_recall_tb_top.sv
// self-checking bench for the store/recall host controller
// assumes shortened timing parameters; the busy wire is resolved here
`timescale 1ns/1ps
`include "nvsr_cfg.svh"
module nvsr_store_recall_tb_top
    import nvsr_pkg::*;
;
    // ----------------------------------------
    // harness
    // ----------------------------------------
    localparam int GR = 12, ST = 10, RC = 10, PU = 20;
    typedef struct packed {
        nvsr_cmd_t   cmd;
        logic [16:0] a;
        logic [7:0]  d;
        logic [7:0]  exp;
    } nvsr_row_t;
    nvsr_row_t rows [6] = '{'{CMD_WRITE, 17'h00003, 8'h5a, 8'h00},
        '{CMD_READ, 17'h00003, 8'h00, 8'h5a},
        '{CMD_WRITE, 17'h1ff00, 8'hc3, 8'h00},
        '{CMD_READ, 17'h1ff00, 8'h00, 8'hc3},
        '{CMD_WRITE, 17'h000ff, 8'h3c, 8'h00},
        '{CMD_READ, 17'h000ff, 8'h00, 8'h3c}};
    logic sys_clk, nrst, req_valid, req_ready, rsp_valid, dev_busy;
    logic mem_dq_oe, hsb_n_o, hsb_n_oe, pull_low, ext_low, auto_en;
    logic [7:0] rsp_rdata, mem_dq_o, mem_dq_i, rd, n_st, n_rc, s0;
    nvsr_req_t req;
    nvsr_mem_ctl_t mem_ctl;
    int lat, bad_count, check_count, cyc;
    wire hsb_n_i = !(hsb_n_oe || pull_low || ext_low);
    nvsr_host #(.GRACE_CYC(GR), .STORE_CYC(ST), .RECALL_CYC(RC),
        .PWRUP_CYC(PU)) uut (.sys_clk(sys_clk), .nrst(nrst),
        .req_valid(req_valid), .req_ready(req_ready), .req(req),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .dev_busy(dev_busy),
        .mem_ctl(mem_ctl), .mem_dq_o(mem_dq_o), .mem_dq_oe(mem_dq_oe),
        .mem_dq_i(mem_dq_i), .hsb_n_o(hsb_n_o), .hsb_n_oe(hsb_n_oe),
        .hsb_n_i(hsb_n_i));
    nvsr_dev_model #(.GRACE(GR), .BUSY(ST)) dev (.sys_clk(sys_clk),
        .nrst(nrst), .mem_ctl(mem_ctl), .dq_w(mem_dq_o),
        .host_low(hsb_n_oe), .dq_r(mem_dq_i), .pull_low(pull_low),
        .n_store(n_st), .n_recall(n_rc), .auto_en(auto_en));
    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: byte %h want %h", $time, got, exp);
        end
    endtask : chk_byte
    task automatic chk_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: flag %b want %b", $time, got, exp);
        end
    endtask : chk_bit
    task automatic do_req(input nvsr_cmd_t c, input logic [16:0] a,
                          input logic [7:0] d);
        req = '{c, a, d};
        req_valid = 1'b1;
        while (req_ready !== 1'b1)
            @(posedge sys_clk) #1;
        @(posedge sys_clk) #1;
        req_valid = 1'b0;
        lat = 0;
        while (rsp_valid !== 1'b1)
        begin
            @(posedge sys_clk) #1;
            lat++;
        end
        rd = rsp_rdata;
    endtask : do_req
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            tally_and_finish();
        end
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        {nrst, req_valid, ext_low, req, bad_count, check_count, cyc} = '0;
        repeat (5) @(posedge sys_clk);
        #1 nrst = 1'b1;
        chk_bit(auto_en, 1'b1);
        foreach (rows[i])
        begin
            do_req(rows[i].cmd, rows[i].a, rows[i].d);
            chk_bit(lat == 2, 1'b1);
            if (rows[i].cmd == CMD_READ)
                chk_byte(rd, rows[i].exp);
        end
        $display("test table done");
        s0 = n_st;
        do_req(CMD_STORE, 17'h0, 8'h00);
        chk_byte(n_st, s0 + 8'h01);
        chk_bit(lat >= 16 + ST, 1'b1);
        do_req(CMD_WRITE, 17'h00003, 8'h77);
        do_req(CMD_RECALL, 17'h0, 8'h00);
        chk_byte(n_rc, 8'h01);
        do_req(CMD_READ, 17'h00003, 8'h00);
        chk_byte(rd, 8'h5a);
        $display("test store recall done");
        do_req(CMD_AUTO_OFF, 17'h0, 8'h00);
        chk_bit(auto_en, 1'b0);
        chk_byte(n_st, s0 + 8'h02);
        do_req(CMD_AUTO_ON, 17'h0, 8'h00);
        chk_bit(auto_en, 1'b1);
        $display("test power-loss setting done");
        do_req(CMD_WRITE, 17'h00003, 8'h99);
        do_req(CMD_HW_STORE, 17'h0, 8'h00);
        chk_byte(n_st, s0 + 8'h04);
        do_req(CMD_HW_STORE, 17'h0, 8'h00);
        chk_byte(n_st, s0 + 8'h04);
        $display("test hardware store done");
        ext_low = 1'b1;
        req = '{CMD_WRITE, 17'h00003, 8'h12};
        req_valid = 1'b1;
        repeat (5)
        begin
            @(posedge sys_clk) #1;
            chk_bit(req_ready, 1'b0);
            chk_bit(dev_busy, 1'b1);
            chk_bit(mem_ctl.ce_n, 1'b1);
            chk_bit(mem_dq_oe, 1'b0);
            chk_bit(hsb_n_oe, 1'b0);
        end
        req_valid = 1'b0;
        ext_low = 1'b0;
        do_req(CMD_WRITE, 17'h00003, 8'h12);
        $display("test busy pin done");
        nrst = 1'b0;
        repeat (2) @(posedge sys_clk) #1;
        chk_bit(mem_ctl.ce_n, 1'b1);
        chk_bit(req_ready, 1'b0);
        chk_bit(hsb_n_o, 1'b0);
        chk_bit(mem_dq_oe, 1'b0);
        nrst = 1'b1;
        repeat (PU)
        begin
            chk_bit(req_ready, 1'b0);
            @(posedge sys_clk) #1;
        end
        do_req(CMD_READ, 17'h00003, 8'h00);
        chk_byte(rd, 8'h99);
        $display("test power-up recall done");
        tally_and_finish();
    end
endmodule : nvsr_store_recall_tb_top
